//--- video_input_config_select.v
// Purpose: chooses strap or register control for mode, gain and input select
// Assumes: register port comes from the serial-bus slave on clk_in
// Notes:   all outputs registered; strap changes take effect 3 edges later
//          read data is a flop, so it shows a register one edge after the offset
//          register fields are kept in strap mode, so a mode switch uses them at once
//          the unused configuration strap has no port; the board keeps it low
//
// Operation
// - control-source strap low: gain and input choice come from straps.
// - in strap mode, gain and input register fields have no effect.
// - control-source strap high: input choice is converter_ctrl_one bit 0.
// - standard and format straps honoured only while mode_reg_a bit 0 is 0.
// - standard strap low NTSC, high PAL; format low rec.601, high square.
// - mode_reg_c bit 7 set: detected standard replaces the standard strap.
// - NTSC 4fsc only via mode_reg_a bits 5:3, never via straps.
// - output strap low BT.656 with codes, high plain 8-bit Y/CbCr.
// - 3-bit gain strap code selects amp gain step in pin mode.
// - pin mode input strap 0 first composite, 1 second composite.
// - register input-select bit resets to 0, first composite input.
// - converter-stop input halts the converter; held low normally.
// - clamp field 111 in converter_ctrl_two raises sync-tip clamp level.
`timescale 1ns/10ps
`include "video_cfg_consts.vh"
module video_input_config_select (
  input  wire       clk_in,                // 10 MHz system clock
  input  wire       rstn_in,               // async reset, active low
  input  wire       ctrl_source_strap_in,  // 0 pin mode, 1 register mode
  input  wire       format_strap_in,       // 0 rec.601, 1 square pixel
  input  wire       standard_strap_in,     // 0 NTSC, 1 PAL
  input  wire       output_format_strap_in,// 0 BT.656, 1 plain Y/CbCr
  input  wire       input_select_strap_in, // composite input choice strap
  input  wire [2:0] gain_code_straps_in,   // amplifier gain strap code
  input  wire       converter_stop_in,     // converter stop pin, high halts
  input  wire       detected_pal_in,       // auto-identified standard, 1 PAL
  input  wire [7:0] reg_addr_in,           // register offset
  input  wire [7:0] reg_wdata_in,          // register write data
  input  wire       reg_wr_in,             // write strobe, one cycle
  output wire [7:0] reg_rdata_out,         // read data for reg_addr_in
  output reg  [2:0] gain_code_out,         // selected amplifier gain step
  output reg        input_second_out,      // 1 second composite input
  output reg        standard_pal_out,      // 1 PAL, 0 NTSC
  output reg  [1:0] sampling_mode_out,     // 601, square or 4fsc
  output reg        output_plain_out,      // 1 plain Y/CbCr, 0 BT.656
  output reg        clamp_raise_out,       // raise sync-tip clamp level
  output reg        converter_halt_out     // stop the converter
);

  // ==========================================================================
  // strap synchroniser
  wire [`STRAP_WIDTH:0] strap_raw;
  wire [`STRAP_WIDTH:0] strap_s;

  // order must match the strap bit positions in the header
  assign strap_raw = {gain_code_straps_in, converter_stop_in, input_select_strap_in,
                      output_format_strap_in, standard_strap_in, format_strap_in,
                      ctrl_source_strap_in};

  strap_sync #(
    .WIDTH (`STRAP_WIDTH + 1)
  ) u_strap_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in (strap_raw),
    .sync_out (strap_s)
  );

  // gain bits cross one by one; a strap change may show a mixed code for a cycle
  wire       pin_mode  = ~strap_s[`ST_CTRL_SRC];
  wire [2:0] gain_pins = strap_s[`ST_GAIN_HI:`ST_GAIN_LO];

  // ==========================================================================
  // registers
  // four byte registers, each read back exactly as written
  reg [7:0] mode_reg_a_reg;
  reg [7:0] mode_reg_c_reg;
  reg [7:0] converter_ctrl_one_reg;
  reg [7:0] converter_ctrl_two_reg;

  // writes always land; strap mode just ignores the gain and input fields on use
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_reg_a_reg         <= `REG_RESET_VAL;
      mode_reg_c_reg         <= `REG_RESET_VAL;
      converter_ctrl_one_reg <= `REG_RESET_VAL;
      converter_ctrl_two_reg <= `REG_RESET_VAL;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `MODE_REG_A_ADDR:    mode_reg_a_reg         <= reg_wdata_in;
        `MODE_REG_C_ADDR:    mode_reg_c_reg         <= reg_wdata_in;
        `CONV_CTRL_ONE_ADDR: converter_ctrl_one_reg <= reg_wdata_in;
        `CONV_CTRL_TWO_ADDR: converter_ctrl_two_reg <= reg_wdata_in;
        default: begin
          // unmapped offsets: the write is dropped
        end
      endcase
    end
  end

  // unmapped offsets read as zero so a host scan sees no ghosts
  reg [7:0] rdata_mux;
  always @* begin
    case (reg_addr_in)
      `MODE_REG_A_ADDR:    rdata_mux = mode_reg_a_reg;
      `MODE_REG_C_ADDR:    rdata_mux = mode_reg_c_reg;
      `CONV_CTRL_ONE_ADDR: rdata_mux = converter_ctrl_one_reg;
      `CONV_CTRL_TWO_ADDR: rdata_mux = converter_ctrl_two_reg;
      default:             rdata_mux = `REG_READ_ZERO;
    endcase
  end

  // ==========================================================================
  // read data
  // one cycle of read latency buys a flop-driven data output
  reg [7:0] rdata_reg;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= `REG_READ_ZERO;
    end else begin
      rdata_reg <= rdata_mux;
    end
  end
  assign reg_rdata_out = rdata_reg;

  // ==========================================================================
  // selection
  // override hands standard, format and output format to mode_reg_a
  wire       override  = mode_reg_a_reg[`MRA_OVERRIDE_BIT];
  wire       auto_std  = mode_reg_c_reg[`MRC_AUTO_STD_BIT];
  wire [2:0] samp_code = mode_reg_a_reg[`MRA_SAMPLE_HI:`MRA_SAMPLE_LO];

  reg [2:0] gain_next;
  reg       input_next;
  reg       pal_next;
  reg [1:0] smode_next;
  reg       outfmt_next;
  // decoded register sampling code
  reg       reg_pal;
  reg [1:0] reg_smode;

  always @* begin
    // unknown register codes fall back to NTSC rec.601
    case (samp_code)
      `SAMP_NTSC_SQ: begin
        reg_pal   = 1'b0;
        reg_smode = `SMODE_SQUARE;
      end
      `SAMP_NTSC_4FSC: begin
        reg_pal   = 1'b0;
        reg_smode = `SMODE_4FSC;
      end
      `SAMP_PAL_601: begin
        reg_pal   = 1'b1;
        reg_smode = `SMODE_601;
      end
      `SAMP_PAL_SQ: begin
        reg_pal   = 1'b1;
        reg_smode = `SMODE_SQUARE;
      end
      default: begin
        reg_pal   = 1'b0;
        reg_smode = `SMODE_601;
      end
    endcase
  end

  // gain and input source follow the control-source strap only
  always @* begin
    if (pin_mode) begin
      gain_next  = gain_pins;
      input_next = strap_s[`ST_INSEL];
    end else begin
      gain_next  = converter_ctrl_two_reg[`CC2_GAIN_HI:`CC2_GAIN_LO];
      input_next = converter_ctrl_one_reg[`CC1_INPUT_BIT];
    end
  end

  // mode straps yield to the override bit; auto-detect beats both for the standard
  always @* begin
    if (!override) begin
      // strap path can only reach 601 or square, never 4fsc
      pal_next    = strap_s[`ST_STANDARD];
      smode_next  = strap_s[`ST_FORMAT] ? `SMODE_SQUARE : `SMODE_601;
      outfmt_next = strap_s[`ST_OUTFMT];
    end else begin
      pal_next    = reg_pal;
      smode_next  = reg_smode;
      outfmt_next = mode_reg_a_reg[`MRA_OUTFMT_BIT];
    end

    if (auto_std) begin
      pal_next = detected_pal_in;
    end
  end

  // ==========================================================================
  // registered outputs
  // one flop stage after the selection keeps the outputs free of mux glitches
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gain_code_out      <= `GAIN_RESET_CODE;
      input_second_out   <= `FLAG_RESET;
      standard_pal_out   <= `FLAG_RESET;
      sampling_mode_out  <= `SMODE_601;
      output_plain_out   <= `FLAG_RESET;
      clamp_raise_out    <= `FLAG_RESET;
      converter_halt_out <= `FLAG_RESET;
    end else begin
      gain_code_out      <= gain_next;
      input_second_out   <= input_next;
      standard_pal_out   <= pal_next;
      sampling_mode_out  <= smode_next;
      output_plain_out   <= outfmt_next;
      clamp_raise_out    <= (converter_ctrl_two_reg[`CC2_CLAMP_HI:`CC2_CLAMP_LO]
                             == `CLAMP_RAISE_CODE);
      // stop pin is treated like the straps: two flops, then this one
      converter_halt_out <= strap_s[`ST_STOP];
    end
  end

endmodule

//--- video_cfg_consts.vh
// Purpose: named constants for the video input configuration select block
// Assumes: 8-bit register port driven by the serial-bus slave on the same clock
// Notes:   definitions only
`ifndef VIDEO_CFG_CONSTS_VH
`define VIDEO_CFG_CONSTS_VH

// ==========================================================================
// register offsets and reset values
`define MODE_REG_A_ADDR      8'h00
`define MODE_REG_C_ADDR      8'h02
`define CONV_CTRL_ONE_ADDR   8'h1e
`define CONV_CTRL_TWO_ADDR   8'h1f
`define REG_RESET_VAL        8'h00
`define REG_READ_ZERO        8'h00
`define GAIN_RESET_CODE      3'h0
`define FLAG_RESET           1'b0

// ==========================================================================
// field positions and clamp raise code
`define MRA_OVERRIDE_BIT     0
`define MRA_SAMPLE_HI        5
`define MRA_SAMPLE_LO        3
`define MRA_OUTFMT_BIT       7
`define MRC_AUTO_STD_BIT     7
`define CC1_INPUT_BIT        0
`define CC2_GAIN_HI          6
`define CC2_GAIN_LO          4
`define CC2_CLAMP_HI         3
`define CC2_CLAMP_LO         1
`define CLAMP_RAISE_CODE     3'h7

// ==========================================================================
// register sampling codes in mode_reg_a[5:3]
`define SAMP_NTSC_601        3'h0
`define SAMP_NTSC_SQ         3'h1
`define SAMP_NTSC_4FSC       3'h2
`define SAMP_PAL_601         3'h3
`define SAMP_PAL_SQ          3'h4

// sampling_mode_out encodings
`define SMODE_601            2'h0
`define SMODE_SQUARE         2'h1
`define SMODE_4FSC           2'h2

// strap vector layout after synchronising
`define STRAP_WIDTH          8
`define ST_CTRL_SRC          0
`define ST_FORMAT            1
`define ST_STANDARD          2
`define ST_OUTFMT            3
`define ST_INSEL             4
`define ST_STOP              5
`define ST_GAIN_LO           6
`define ST_GAIN_HI           8

`endif

//--- strap_sync.v
// Purpose: two-flop synchroniser for a group of static strap pins
// Assumes: straps are quasi-static; bits are not guaranteed to land together
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module strap_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_in,   // system clock
  input  wire             rstn_in,  // async reset, active low
  input  wire [WIDTH-1:0] async_in, // raw pin levels
  output wire [WIDTH-1:0] sync_out  // synchronised levels
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  // ==========================================================================
  // two stages
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg   <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule

//--- cfg_monitor.sv
// Purpose: port-level checks of the video input configuration select block
// Assumes: every register change is seen as a write on the register port
// Notes:   shadows the four registers from observed writes
`timescale 1ns/10ps
`include "video_cfg_consts.vh"
module cfg_monitor (
  input wire       clk_in,
  input wire       rstn_in,
  input wire       ctrl_source_strap_in,
  input wire       format_strap_in,
  input wire       standard_strap_in,
  input wire       output_format_strap_in,
  input wire       input_select_strap_in,
  input wire [2:0] gain_code_straps_in,
  input wire       converter_stop_in,
  input wire       detected_pal_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire       reg_wr_in,
  input wire [7:0] reg_rdata_out,
  input wire [2:0] gain_code_out,
  input wire       input_second_out,
  input wire       standard_pal_out,
  input wire [1:0] sampling_mode_out,
  input wire       output_plain_out,
  input wire       clamp_raise_out,
  input wire       converter_halt_out
);
  reg [7:0] mode_a_reg, mode_c_reg, ctl1_reg, ctl2_reg;
  // strap paths only judged once three edges have passed since reset
  reg [1:0] settle_reg;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {mode_a_reg, mode_c_reg, ctl1_reg, ctl2_reg} <= 32'h0;
      settle_reg <= 2'h0;
    end else begin
      if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
      if (reg_wr_in && reg_addr_in == `MODE_REG_A_ADDR) mode_a_reg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `MODE_REG_C_ADDR) mode_c_reg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `CONV_CTRL_ONE_ADDR) ctl1_reg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `CONV_CTRL_TWO_ADDR) ctl2_reg <= reg_wdata_in;
    end
  end
  // ========
  // assertions
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  chk_halt_sync: assert property (
    settle_reg == 2'h3 |-> converter_halt_out == $past(converter_stop_in, 3))
    else $error("halt does not follow stop pin");
  chk_pin_path: assert property (
    settle_reg == 2'h3 && !$past(ctrl_source_strap_in, 3) |->
    gain_code_out == $past(gain_code_straps_in, 3)
    && input_second_out == $past(input_select_strap_in, 3))
    else $error("pin mode gain or input wrong");
  chk_reg_path: assert property (
    settle_reg == 2'h3 && $past(ctrl_source_strap_in, 3) |->
    gain_code_out == $past(ctl2_reg[6:4]) && input_second_out == $past(ctl1_reg[0]))
    else $error("register mode gain or input wrong");
  chk_std_auto: assert property (
    $past(mode_c_reg[7]) |-> standard_pal_out == $past(detected_pal_in))
    else $error("detected standard not used");
  chk_std_pin: assert property (
    settle_reg == 2'h3 && !$past(mode_c_reg[7]) && !$past(mode_a_reg[0]) |->
    standard_pal_out == $past(standard_strap_in, 3))
    else $error("standard strap not honoured");
  chk_fmt_pin: assert property (
    settle_reg == 2'h3 && !$past(mode_a_reg[0]) |->
    sampling_mode_out == {1'b0, $past(format_strap_in, 3)}
    && output_plain_out == $past(output_format_strap_in, 3))
    else $error("format straps not honoured");
  chk_clamp_code: assert property (
    clamp_raise_out == ($past(ctl2_reg[3:1]) == `CLAMP_RAISE_CODE))
    else $error("clamp raise wrong");
  chk_unmapped_zero: assert property (
    !($past(reg_addr_in) inside {`MODE_REG_A_ADDR, `MODE_REG_C_ADDR, `CONV_CTRL_ONE_ADDR,
    `CONV_CTRL_TWO_ADDR}) |-> reg_rdata_out == `REG_READ_ZERO)
    else $error("unmapped read not zero");
  chk_read_back: assert property (
    $past(reg_addr_in) == `CONV_CTRL_ONE_ADDR |-> reg_rdata_out == $past(ctl1_reg))
    else $error("input select read back wrong");
endmodule

//--- strap_host.sv
// Purpose: board straps and serial-bus host at the far side of the block
// Assumes: host writes arrive through the plain same-clock register port
// Notes:   pins_out = {det, stop, gain[2:0], insel, outfmt, std, fmt, ctrl}
`timescale 1ns/10ps
module strap_host (
  input  wire       clk_in,    // system clock
  output reg  [9:0] pins_out,  // straps, stop pin, detected standard
  output reg  [7:0] addr_out,  // register offset
  output reg  [7:0] wdata_out, // write data
  output reg        wr_out     // write strobe
);
  wire unused_strap = 1'b0;
  initial begin
    pins_out  = 10'h000;
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
  end
  task set_pins(input [9:0] p);
    @(posedge clk_in);
    pins_out <= p;
  endtask
  task look(input [7:0] a);
    @(posedge clk_in);
    addr_out <= a;
  endtask
  // data inverted after the write so a stale byte never looks valid
  task write(input [7:0] a, input [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask
endmodule

//--- tb.sv
// Purpose: self-checking bench for the configuration select block
// Assumes: strap_host drives every input of the block except clock and reset
// Notes:   random straps and writes mixed with fixed corner steps
`timescale 1ns/10ps
`include "video_cfg_consts.vh"
module tb;
  reg        clk_in = 1'b0;
  reg        rstn_in = 1'b0;
  wire [9:0] pins;
  wire [7:0] addr, wdata, rdata;
  wire       wr, insec, pal, plain, clamp, halt;
  wire [2:0] gain;
  wire [1:0] smode;
  integer    seed = 34;
  integer    mismatches = 0;
  integer    num_checks = 0;
  integer    i;
  reg  [7:0] regs [0:3];
  reg  [7:0] map [0:4];
  always #50 clk_in = ~clk_in;
  strap_host strap_host_i (.clk_in(clk_in), .pins_out(pins), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr));
  video_input_config_select video_input_config_select_i (.clk_in(clk_in),
    .rstn_in(rstn_in), .ctrl_source_strap_in(pins[0]), .format_strap_in(pins[1]),
    .standard_strap_in(pins[2]), .output_format_strap_in(pins[3]),
    .input_select_strap_in(pins[4]), .gain_code_straps_in(pins[7:5]),
    .converter_stop_in(pins[8]), .detected_pal_in(pins[9]), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rdata_out(rdata), .gain_code_out(gain),
    .input_second_out(insec), .standard_pal_out(pal), .sampling_mode_out(smode),
    .output_plain_out(plain), .clamp_raise_out(clamp), .converter_halt_out(halt));
  // ========
  // expectations
  function [7:0] exp_read(input [7:0] ad);
    integer k;
    exp_read = `REG_READ_ZERO;
    for (k = 0; k < 4; k = k + 1)
      if (ad == map[k]) exp_read = regs[k];
  endfunction
  function [1:0] exp_smode(input [7:0] m, input f);
    if (!m[0]) exp_smode = f ? `SMODE_SQUARE : `SMODE_601;
    else if (m[5:3] == `SAMP_NTSC_4FSC) exp_smode = `SMODE_4FSC;
    else if (m[5:3] == `SAMP_NTSC_SQ || m[5:3] == `SAMP_PAL_SQ) exp_smode = `SMODE_SQUARE;
    else exp_smode = `SMODE_601;
  endfunction
  function exp_pal(input [7:0] m, input [7:0] c, input det, input s);
    if (c[7]) exp_pal = det;
    else if (!m[0]) exp_pal = s;
    else exp_pal = m[5:3] == `SAMP_PAL_601 || m[5:3] == `SAMP_PAL_SQ;
  endfunction
  task chk(input string n, input [7:0] e, input [7:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task step(input [9:0] p, input [7:0] a, input [7:0] d);
    integer k;
    strap_host_i.set_pins(p);
    strap_host_i.write(a, d);
    for (k = 0; k < 4; k = k + 1)
      if (a == map[k]) regs[k] = d;
    repeat (4) @(posedge clk_in);
    #1;
    chk("rdata", exp_read(a), rdata);
    chk("gain", p[0] ? regs[3][6:4] : p[7:5], gain);
    chk("input", p[0] ? regs[2][0] : p[4], insec);
    chk("pal", exp_pal(regs[0], regs[1], p[9], p[2]), pal);
    chk("smode", exp_smode(regs[0], p[1]), smode);
    chk("plain", regs[0][0] ? regs[0][7] : p[3], plain);
    chk("clamp", regs[3][3:1] == `CLAMP_RAISE_CODE, clamp);
    chk("halt", p[8], halt);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches = mismatches + 1;
    summarize;
  end
  initial begin
    map[0] = 8'h00;
    map[1] = 8'h02;
    map[2] = 8'h1e;
    map[3] = 8'h1f;
    map[4] = 8'h55;
    for (i = 0; i < 4; i = i + 1) regs[i] = `REG_RESET_VAL;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      strap_host_i.look(map[i]);
      @(posedge clk_in);
      #1;
      chk("reset read", 8'h00, rdata);
    end
    $display("test reset_values done");
    step(10'h000, 8'h1e, 8'h01);
    step(10'h001, 8'h1f, 8'h7e);
    step(10'h0ff, 8'h00, 8'h11);
    step(10'h200, 8'h02, 8'h80);
    step(10'h001, 8'h02, 8'h00);
    step(10'h001, 8'h00, 8'h21);
    step(10'h001, 8'h00, 8'h99);
    step(10'h001, 8'h00, 8'h09);
    $display("test corners done");
    for (i = 0; i < 40; i = i + 1)
      step($random(seed), map[{$random(seed)} % 5], $random(seed));
    $display("test random done");
    summarize;
  end
endmodule
bind video_input_config_select cfg_monitor cfg_monitor_i (.clk_in(clk_in),
  .rstn_in(rstn_in), .ctrl_source_strap_in(ctrl_source_strap_in),
  .format_strap_in(format_strap_in), .standard_strap_in(standard_strap_in),
  .output_format_strap_in(output_format_strap_in),
  .input_select_strap_in(input_select_strap_in), .gain_code_straps_in(gain_code_straps_in),
  .converter_stop_in(converter_stop_in), .detected_pal_in(detected_pal_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rdata_out(reg_rdata_out), .gain_code_out(gain_code_out),
  .input_second_out(input_second_out), .standard_pal_out(standard_pal_out),
  .sampling_mode_out(sampling_mode_out), .output_plain_out(output_plain_out),
  .clamp_raise_out(clamp_raise_out), .converter_halt_out(converter_halt_out));
